// ===== pkg/rhdr_pkg.sv
// Root hub descriptor register bank: shared constants.
// Assumes a command-code register port on the controller clock.
package rhdr_pkg;
    // Command codes
    localparam logic [7:0] CMD_FIRST_RD   = 8'h12;
    localparam logic [7:0] CMD_FIRST_WR   = 8'h92;
    localparam logic [7:0] CMD_SECOND_RD  = 8'h13;
    localparam logic [7:0] CMD_SECOND_WR  = 8'h93;
    // First descriptor field positions
    localparam int PGD_MSB   = 31;
    localparam int PGD_LSB   = 24;
    localparam int NOCR_BIT  = 12;
    localparam int OCRM_BIT  = 11;
    localparam int CDF_BIT   = 10;
    localparam int NPS_BIT   = 9;
    localparam int PSS_BIT   = 8;
    localparam int DPC_MSB   = 1;
    localparam int DPC_LSB   = 0;
    // Second descriptor field positions (two ports, bit 0 reserved)
    localparam int PPM_MSB   = 18;
    localparam int PPM_LSB   = 17;
    localparam int RMV_MSB   = 2;
    localparam int RMV_LSB   = 1;
    localparam int NUM_PORTS = 2;
    // Power-good delay unit in ms
    localparam int PGD_UNIT_MS = 2;
    // Implementation-specific reset values (arbitrary plain choices)
    localparam logic [7:0] PGD_RST       = 8'h01;
    localparam logic       NOCR_RST      = 1'h0;
    localparam logic       NPS_RST       = 1'h0;
    localparam logic       PSS_RST       = 1'h1;
    localparam logic [1:0] DPC_VALUE     = 2'h2;
    localparam logic [1:0] PPM_RST       = 2'h0;
    localparam logic [1:0] RMV_RST       = 2'h0;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
endpackage : rhdr_pkg

// ===== core/rhdr_regs.sv
// Root hub descriptor register bank: first and second descriptor words.
// Assumes a single-cycle command strobe with code and write data on sys_clk_in.
// Functional notes
// R1: Power-good delay byte at bits 31:24.
// R2: Software waits delay times 2 ms.
// R3: Bit 12 set disables overcurrent reporting.
// R4: Bit 11 selects collective or per-port reporting.
// R5: Reset loads bit 11 from bit 8.
// R6: Software writes bit 11 zero, then one.
// R7: Compound device bit always reads zero.
// R8: Bit 9 set means ports always powered.
// R9: Bit 8 selects ganged or individual switching.
// R10: Mask picks per-port or global power commands.
// R11: Bits 1:0 report two downstream ports.
// R12: Second descriptor uses codes 13h and 93h.
// R13: Software initializes second descriptor fields.
// R14: First descriptor uses codes 12h and 92h.
// R15: Descriptors writable in every controller state.
// R16: Reserved and port count bits ignore writes.
`timescale 1ns/1ps
module rhdr_regs
    import rhdr_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_n_in,
    // Command port
    input  wire logic                 cmd_valid_in,
    input  wire logic [7:0]           cmd_code_in,
    input  wire logic [31:0]          cmd_wdata_in,
    output logic      [31:0]          cmd_rdata_out,
    output logic                      cmd_rvalid_out,
    // Power commands from the port status logic
    input  wire logic                 global_power_cmd_in,
    input  wire logic                 global_power_on_in,
    input  wire logic [NUM_PORTS-1:0] per_port_power_cmd_in,
    input  wire logic [NUM_PORTS-1:0] per_port_power_on_in,
    // Decoded descriptor state
    output logic      [NUM_PORTS-1:0] port_power_out,
    output logic                      oc_per_port_out,
    output logic                      oc_report_on_out,
    output logic      [7:0]           power_good_delay_out
);
    // First descriptor fields; reset values are this build's own choice,
    // software rewrites them at start-up to match the board
    logic [7:0]           power_good_delay;
    logic                 no_overcurrent_report;
    logic                 overcurrent_report_mode;
    logic                 no_power_switch;
    logic                 power_switch_style;

    // Second descriptor fields, one bit per downstream port
    logic [NUM_PORTS-1:0] port_power_mask;
    logic [NUM_PORTS-1:0] device_removable;

    // Live port power state, one stage ahead of the registered output
    logic [NUM_PORTS-1:0] port_power;

    // Command match; one helper keeps all four decodes on the same compare
    // and leaves a single place to touch if a code is ever moved
    function automatic logic rhdr_cmd_hit
    (
        input logic       valid,
        input logic [7:0] code,
        input logic [7:0] want
    );
        rhdr_cmd_hit = valid && (code == want);
    endfunction : rhdr_cmd_hit

    // Command decode; no state gating, so writes land in every USB state
    // Unknown codes match nothing and are dropped without an answer
    wire logic wr_first  = rhdr_cmd_hit(cmd_valid_in, cmd_code_in, CMD_FIRST_WR);   // [R14] [R15]
    wire logic wr_second = rhdr_cmd_hit(cmd_valid_in, cmd_code_in, CMD_SECOND_WR);  // [R12] [R15]
    wire logic rd_first  = rhdr_cmd_hit(cmd_valid_in, cmd_code_in, CMD_FIRST_RD);   // [R14]
    wire logic rd_second = rhdr_cmd_hit(cmd_valid_in, cmd_code_in, CMD_SECOND_RD);  // [R12]

    // Either read code raises the answer strobe one cycle later
    wire logic rd_any    = rd_first || rd_second;

    // Next delay byte; only exposed here, the wait itself is software's
    logic [7:0]           next_power_good_delay;
    assign next_power_good_delay = wr_first ? cmd_wdata_in[PGD_MSB:PGD_LSB] : power_good_delay; // [R1]

    // Next overcurrent fields; the style bit is kept even while
    // reporting is off, so it is ready when reporting comes back
    logic                 next_no_overcurrent_report;
    logic                 next_overcurrent_report_mode;
    assign next_no_overcurrent_report   = wr_first ? cmd_wdata_in[NOCR_BIT] : no_overcurrent_report;   // [R3]
    assign next_overcurrent_report_mode = wr_first ? cmd_wdata_in[OCRM_BIT] : overcurrent_report_mode; // [R4]

    // Next switching fields; the compound bit has no storage at all,
    // so a write to it is simply lost and it reads back as zero
    logic                 next_no_power_switch;
    logic                 next_power_switch_style;
    assign next_no_power_switch    = wr_first ? cmd_wdata_in[NPS_BIT] : no_power_switch;    // [R8] [R7]
    assign next_power_switch_style = wr_first ? cmd_wdata_in[PSS_BIT] : power_switch_style; // [R9]

    // Next second descriptor fields; bit 0 and bit 16 stay unused
    logic [NUM_PORTS-1:0] next_port_power_mask;
    logic [NUM_PORTS-1:0] next_device_removable;
    assign next_port_power_mask  = wr_second ? cmd_wdata_in[PPM_MSB:PPM_LSB] : port_power_mask;   // [R10]
    assign next_device_removable = wr_second ? cmd_wdata_in[RMV_MSB:RMV_LSB] : device_removable; // [R12]

    // Next decoded outputs; the style only counts while reporting is on
    logic                 next_oc_report_on;
    logic                 next_oc_per_port;
    assign next_oc_report_on = !no_overcurrent_report;                            // [R3]
    assign next_oc_per_port  = !no_overcurrent_report && overcurrent_report_mode; // [R4]

    // First word read view; reserved bits and the compound flag tie to zero
    // The port count is a constant, so no write can ever disturb it
    logic [31:0] first_word;
    always_comb
    begin
        first_word                  = ZERO_WORD;                            // [R16]
        first_word[PGD_MSB:PGD_LSB] = power_good_delay;                     // [R1]
        first_word[NOCR_BIT]        = no_overcurrent_report;                // [R3]
        first_word[OCRM_BIT]        = overcurrent_report_mode;              // [R4]
        first_word[CDF_BIT]         = 1'h0;                                 // [R7]
        first_word[NPS_BIT]         = no_power_switch;                      // [R8]
        first_word[PSS_BIT]         = power_switch_style;                   // [R9]
        first_word[DPC_MSB:DPC_LSB] = DPC_VALUE;                            // [R11]
    end

    // Second word read view; only the mask and removable pairs hold state
    // Everything else in this word reads as zero whatever was written
    logic [31:0] second_word;
    always_comb
    begin
        second_word                  = ZERO_WORD;                           // [R16]
        second_word[PPM_MSB:PPM_LSB] = port_power_mask;                     // [R12]
        second_word[RMV_MSB:RMV_LSB] = device_removable;                    // [R12]
    end

    // Read mux; a cycle without a read shows zero, so old data never lingers
    // on the bus and a missed strobe cannot be mistaken for an answer
    logic [31:0] next_rdata;
    logic        next_rvalid;
    assign next_rdata  = rd_first ? first_word : (rd_second ? second_word : ZERO_WORD);
    assign next_rvalid = rd_any;

    // Power-good delay byte; held as written and only passed out
    // Driver software times its post-power wait from this value,
    // so the block itself never counts the delay down
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            power_good_delay <= PGD_RST;
        else
            power_good_delay <= next_power_good_delay;                      // [R1]
    end

    // Overcurrent reporting enable, stored inverted as in the word
    // Set means no overcurrent reporting at all
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            no_overcurrent_report <= NOCR_RST;
        else
            no_overcurrent_report <= next_no_overcurrent_report;            // [R3]
    end

    // Overcurrent style; reset copies the switching style so the two
    // modes agree until software picks its own reporting style
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            overcurrent_report_mode <= PSS_RST;                             // [R5]
        else
            overcurrent_report_mode <= next_overcurrent_report_mode;        // [R4]
    end

    // Always-powered flag; while set the switching style is ignored
    // and both ports are held on
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            no_power_switch <= NPS_RST;
        else
            no_power_switch <= next_no_power_switch;                        // [R8]
    end

    // Switching style: ganged when clear, individual when set
    // Only meaningful while the always-powered flag is clear
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            power_switch_style <= PSS_RST;
        else
            power_switch_style <= next_power_switch_style;                  // [R9]
    end

    // Per-port power mask; in individual mode a set bit moves that port to its own commands
    // Changing it mid-run leaves the port's power level where it was
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            port_power_mask <= PPM_RST;
        else
            port_power_mask <= next_port_power_mask;                        // [R10]
    end

    // Removable flags; stored for software only, no logic reads them
    // beyond the read view of the second word
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            device_removable <= RMV_RST;
        else
            device_removable <= next_device_removable;                      // [R12]
    end

    // Per-port power state; always-powered wins, then ganged or masked selection.
    // A port that follows its own commands ignores every global pulse, so software
    // must set the mask before it relies on per-port switching.
    // Command pulses are expected from logic on this same clock.
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            // Source select: own commands only in individual mode with the mask set
            wire logic use_port_cmd = !no_power_switch && power_switch_style && port_power_mask[p]; // [R10]

            // Pulse and level from the selected source
            wire logic take_cmd     = use_port_cmd ? per_port_power_cmd_in[p] : global_power_cmd_in; // [R9]
            wire logic cmd_level    = use_port_cmd ? per_port_power_on_in[p] : global_power_on_in;   // [R10]

            // Unswitched ports stay on; switched ports hold until a command arrives
            wire logic next_power   = no_power_switch ? 1'h1 : (take_cmd ? cmd_level : port_power[p]); // [R8] [R9]

            // Port state register; reset leaves every port unpowered
            // until software or the always-powered flag says otherwise
            always_ff @(posedge sys_clk_in)
            begin
                if (!rst_n_in)
                    port_power[p] <= 1'h0;
                else
                    port_power[p] <= next_power;
            end
        end
    endgenerate

    // Read data output; stands for one cycle after the read command
    // and is zero otherwise, so a reader must take it at that edge
    // or issue the read again
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            cmd_rdata_out <= ZERO_WORD;
        else
            cmd_rdata_out <= next_rdata;                                    // [R14]
    end

    // Read answer strobe, a one-cycle pulse per read command
    // Writes never raise it, they are silent
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            cmd_rvalid_out <= 1'h0;
        else
            cmd_rvalid_out <= next_rvalid;                                  // [R12]
    end

    // Overcurrent reporting enable for the port status logic
    // Lags the field by one cycle, as do the per-port flag and the delay copy; port power lags by two
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            oc_report_on_out <= 1'h0;
        else
            oc_report_on_out <= next_oc_report_on;                          // [R3]
    end

    // Per-port reporting flag, forced low while reporting is off
    // so downstream logic never needs to check both bits
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            oc_per_port_out <= 1'h0;
        else
            oc_per_port_out <= next_oc_per_port;                            // [R4]
    end

    // Power-good delay copy for the power sequencing logic
    // Still in 2 ms units; scaling is left to the consumer
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            power_good_delay_out <= 8'h00;
        else
            power_good_delay_out <= power_good_delay;                       // [R1]
    end

    // Port power outputs, one stage behind the internal state
    // so the pins always come straight from a flip-flop
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            port_power_out <= '0;
        else
            port_power_out <= port_power;                                   // [R8]
    end
endmodule : rhdr_regs

// ===== tb/rhdr_regs_props.sv
// Checker for the descriptor register bank ports.
// Assumes it is bound to rhdr_regs, one clock domain.
`timescale 1ns/1ps
module rhdr_regs_props
    import rhdr_pkg::*;
(
    // Clock, reset and command port
    input wire logic                 sys_clk_in, rst_n_in, cmd_valid_in, cmd_rvalid_out,
    input wire logic [7:0]           cmd_code_in, power_good_delay_out,
    input wire logic [31:0]          cmd_wdata_in, cmd_rdata_out,
    // Decoded state
    input wire logic [NUM_PORTS-1:0] port_power_out,
    input wire logic                 oc_per_port_out, oc_report_on_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Named decodes keep the properties short
    wire rd_cmd = cmd_valid_in && (cmd_code_in == CMD_FIRST_RD || cmd_code_in == CMD_SECOND_RD);
    wire wr_first = cmd_valid_in && cmd_code_in == CMD_FIRST_WR;
    read_answer_a: assert property (rd_cmd |=> cmd_rvalid_out) else $error("read not answered");
    idle_quiet_a: assert property (!rd_cmd |=> !cmd_rvalid_out && cmd_rdata_out == ZERO_WORD)
        else $error("read data without read");
    first_fixed_a: assert property (cmd_rvalid_out && $past(cmd_code_in) == CMD_FIRST_RD |->
        cmd_rdata_out[23:13] == 11'h000 && !cmd_rdata_out[10] && cmd_rdata_out[7:0] == 8'h02) else $error("fixed bits");
    second_fixed_a: assert property (cmd_rvalid_out && $past(cmd_code_in) == CMD_SECOND_RD |->
        (cmd_rdata_out & 32'hfff9_fff9) == ZERO_WORD) else $error("second reserved bits");
    delay_out_a: assert property (wr_first |=> ##1 power_good_delay_out == $past(cmd_wdata_in[31:24], 2))
        else $error("delay output");
    oc_on_a: assert property (wr_first |=> ##1 oc_report_on_out == !$past(cmd_wdata_in[12], 2))
        else $error("overcurrent enable");
    oc_style_a: assert property (wr_first |=> ##1 oc_per_port_out ==
        (!$past(cmd_wdata_in[12], 2) && $past(cmd_wdata_in[11], 2))) else $error("overcurrent style");
    always_pwr_a: assert property (wr_first && cmd_wdata_in[9] |-> ##[2:4] port_power_out == 2'h3)
        else $error("ports not powered");
    wr_rd_a: assert property (wr_first ##1 (cmd_valid_in && cmd_code_in == CMD_FIRST_RD) |=>
        cmd_rdata_out[31:24] == $past(cmd_wdata_in[31:24], 2)) else $error("read after write");
endmodule : rhdr_regs_props

// ===== tb/rhdr_regs_bench.sv
// Self-checking bench for the descriptor register bank.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
module rhdr_regs_bench;
    import rhdr_pkg::*;
    logic        sys_clk_in = 1'h0, rst_n_in = 1'h0, cmd_valid_in = 1'h0, gcmd = 1'h0, gon = 1'h0;
    logic [7:0]  cmd_code_in = 8'h00, power_good_delay_out;
    logic [31:0] cmd_wdata_in = 32'h0, cmd_rdata_out;
    logic [1:0]  pcmd = 2'h0, pon = 2'h0, port_power_out;
    logic        cmd_rvalid_out, oc_per_port_out, oc_report_on_out;
    int          errors = 0, checked = 0;
    // 200 MHz clock
    always #2.5 sys_clk_in = ~sys_clk_in;
    rhdr_regs i_rhdr_regs (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
        .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
        .cmd_rvalid_out(cmd_rvalid_out), .global_power_cmd_in(gcmd), .global_power_on_in(gon),
        .per_port_power_cmd_in(pcmd), .per_port_power_on_in(pon), .port_power_out(port_power_out),
        .oc_per_port_out(oc_per_port_out), .oc_report_on_out(oc_report_on_out),
        .power_good_delay_out(power_good_delay_out));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Strobe is left high so a read may follow a write back to back
    task op(input logic [7:0] c, input logic [31:0] d);
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'h1;
        cmd_code_in  <= c;
        cmd_wdata_in <= d;
    endtask : op
    // Answer stands one cycle, so it is looked at just after its edge
    task rd(input logic [7:0] c, input logic [31:0] e);
        op(c, 32'h0);
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'h0;
        #1 chk("read data", cmd_rdata_out, e);
        chk("read valid", cmd_rvalid_out, 32'h1);
    endtask : rd
    // One power command pulse, then port state after it has settled
    task pw(input logic g, input logic [1:0] p, input logic [1:0] on, input logic [1:0] e);
        @(posedge sys_clk_in);
        gcmd <= g;
        gon  <= on[0];
        pcmd <= p;
        pon  <= on;
        @(posedge sys_clk_in);
        gcmd <= 1'h0;
        pcmd <= 2'h0;
        repeat (2) @(posedge sys_clk_in);
        #1 chk("port power", port_power_out, e);
    endtask : pw
    task end_of_test;
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'h1;
        rd(CMD_FIRST_RD, 32'h0100_0902);
        chk("decoded", {oc_report_on_out, oc_per_port_out, power_good_delay_out}, 32'h301);
        chk("settle ms", power_good_delay_out * PGD_UNIT_MS, 32'h2);
        rd(CMD_SECOND_RD, ZERO_WORD);
        op(CMD_FIRST_WR, 32'hffff_ffff);
        rd(CMD_FIRST_RD, 32'hff00_1b02);
        chk("decoded", {oc_report_on_out, oc_per_port_out, power_good_delay_out}, 32'h0ff);
        for (int i = 0; i < 2; i++)
        begin
            op(CMD_FIRST_WR, {20'h0, i[0], 11'h0});
            rd(CMD_FIRST_RD, {20'h0, i[0], 11'h2});
            chk("per port", oc_per_port_out, i[0]);
        end
        pw(1'h1, 2'h0, 2'h3, 2'h3);
        op(CMD_SECOND_WR, 32'hffff_ffff);
        rd(CMD_SECOND_RD, 32'h0006_0006);
        op(CMD_SECOND_WR, 32'h0002_0000);
        op(CMD_FIRST_WR, 32'h0000_0100);
        rd(CMD_FIRST_RD, 32'h0000_0102);
        pw(1'h1, 2'h0, 2'h0, 2'h1);
        pw(1'h0, 2'h3, 2'h0, 2'h0);
        pw(1'h1, 2'h0, 2'h3, 2'h2);
        end_of_test;
    end
    // Watchdog
    initial
    begin
        repeat (2000) @(posedge sys_clk_in);
        errors++;
        end_of_test;
    end
endmodule : rhdr_regs_bench
bind rhdr_regs rhdr_regs_props i_rhdr_regs_props (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_rvalid_out(cmd_rvalid_out), .cmd_code_in(cmd_code_in),
    .power_good_delay_out(power_good_delay_out), .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
    .port_power_out(port_power_out), .oc_per_port_out(oc_per_port_out), .oc_report_on_out(oc_report_on_out));
